/* src/exec_pkg.sv */
package exec_pkg;

  // Status flag bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle costs of each outcome.
  localparam logic [1:0] CYC_NO_SKIP = 2'h1;
  localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;
  localparam logic [1:0] CYC_BRANCH_NOT = 2'h1;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_IO_BIT = 2'h2;

  // APB byte offsets.
  localparam logic [7:0] OFS_STATUS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_RETIRED = 8'h08;
  localparam logic [7:0] OFS_TAKEN = 8'h0C;
  localparam logic [7:0] OFS_LAST = 8'h10;
  localparam logic [7:0] OFS_IO_BASE = 8'h40;

  // Field positions in the last-outcome register.
  localparam int LAST_CYC_LSB = 0;
  localparam int LAST_TAKEN_BIT = 4;
  localparam int LAST_OP_LSB = 8;

  // Reset values.
  localparam logic [7:0] RST_STATUS_FLAGS = 8'h00;
  localparam logic [7:0] RST_IO = 8'h00;

  typedef enum logic [4:0] {
    op_nop,
    op_skip_if_reg_bit_one,
    op_skip_if_io_bit_zero,
    op_skip_if_io_bit_one,
    op_branch_on_flag_one,
    op_branch_on_flag_zero,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_carry_one,
    op_branch_carry_zero,
    op_branch_same_or_higher,
    op_branch_lower,
    op_branch_minus,
    op_branch_plus,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_half_carry_one,
    op_branch_half_carry_zero,
    op_branch_transfer_bit_one,
    op_branch_transfer_bit_zero,
    op_branch_overflow_one,
    op_branch_overflow_zero,
    op_branch_irq_enabled,
    op_branch_irq_disabled,
    op_io_bit_force_one,
    op_io_bit_force_zero
  } op_t;

  typedef struct packed {
    op_t op;
    logic [4:0] io_addr;
    logic [2:0] bit_sel;
    logic [2:0] flag_sel;
    logic [6:0] offset;
    logic [7:0] reg_value;
    logic next_two_word;
  } exec_req_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic [1:0] cycles;
  } exec_resp_t;

endpackage

/* src/branch_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module branch_cond_eval
  import exec_pkg::*;
(
  input wire op_t op,
  input wire logic [2:0] flag_sel,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] flags,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] io_value,
  output logic take
);

  logic signed_lt;

  assign signed_lt = flags[FLAG_N] ^ flags[FLAG_V];

  always_comb begin
    case (op)
      op_skip_if_reg_bit_one: take = reg_value[bit_sel]; // RL1
      op_skip_if_io_bit_zero: take = ~io_value[bit_sel]; // RL2
      op_skip_if_io_bit_one: take = io_value[bit_sel]; // RL3
      op_branch_on_flag_one: take = flags[flag_sel]; // RL4
      op_branch_on_flag_zero: take = ~flags[flag_sel]; // RL5
      op_branch_equal: take = flags[FLAG_Z]; // RL13
      op_branch_not_equal: take = ~flags[FLAG_Z]; // RL13
      op_branch_carry_one: take = flags[FLAG_C]; // RL6
      op_branch_carry_zero: take = ~flags[FLAG_C]; // RL6
      op_branch_same_or_higher: take = ~flags[FLAG_C]; // RL6
      op_branch_lower: take = flags[FLAG_C]; // RL6
      op_branch_minus: take = flags[FLAG_N]; // RL13
      op_branch_plus: take = ~flags[FLAG_N]; // RL13
      op_branch_signed_ge: take = ~signed_lt; // RL7
      op_branch_signed_lt: take = signed_lt; // RL8
      op_branch_half_carry_one: take = flags[FLAG_H]; // RL9
      op_branch_half_carry_zero: take = ~flags[FLAG_H]; // RL9
      op_branch_transfer_bit_one: take = flags[FLAG_T]; // RL10
      op_branch_transfer_bit_zero: take = ~flags[FLAG_T]; // RL10
      op_branch_overflow_one: take = flags[FLAG_V]; // RL11
      op_branch_overflow_zero: take = ~flags[FLAG_V]; // RL11
      op_branch_irq_enabled: take = flags[FLAG_I]; // RL12
      op_branch_irq_disabled: take = ~flags[FLAG_I]; // RL12
      default: take = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

/* src/branch_skip_bitop_exec.sv */
// Overview of operation
// (RL1) Skip next instruction when working register bit is one; 1/2/3 cycles.
// (RL2) Skip next instruction when I/O register bit is zero; flags kept.
// (RL3) Skip next instruction when I/O register bit is one; flags kept.
// (RL4) Flag-one branch: chosen flag one loads PC with PC plus offset plus one.
// (RL5) Flag-zero branch: chosen flag zero branches by offset plus one.
// (RL6) Same-or-higher and carry-zero on carry zero; lower, carry-one on one.
// (RL7) Signed greater-or-equal branch taken when N xor V is zero.
// (RL8) Signed less-than branch taken when N xor V is one; 1 or 2 cycles.
// (RL9) Half-carry branches taken on H one or zero respectively.
// (RL10) Transfer-bit branches taken on T one or zero; no flag changes.
// (RL11) Overflow branches taken on V one or zero; offset plus one.
// (RL12) Interrupt branches taken on I one or zero; 1 or 2 cycles.
// (RL13) Equal/not-equal test Z; minus/plus test N.
// (RL14) Force one I/O bit to one in two cycles; flags untouched.
// (RL15) Force one I/O bit to zero in two cycles; flags untouched.
// (RL16) Offset is signed; skip over two-word takes 3 cycles, one-word 2.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module branch_skip_bitop_exec
  import exec_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int IO_REGS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire exec_req_t req,
  output logic req_ready,
  output logic [PC_W-1:0] pc,
  output exec_resp_t resp
);

  if (PC_W < 8 || PC_W > 32) begin : g_bad_pc
    $error("PC_W must lie between 8 and 32");
  end
  if (IO_REGS < 1 || IO_REGS > 32) begin : g_bad_io
    $error("IO_REGS must lie between 1 and 32");
  end

  typedef enum logic {st_idle, st_stall} state_t;

  state_t state_q;
  logic [1:0] stall_left_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] flags_q;
  logic [7:0] io_q [IO_REGS];
  logic [31:0] retired_q;
  logic [31:0] taken_cnt_q;
  logic [31:0] last_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  exec_resp_t resp_q;

  logic accept;
  logic take;
  logic is_skip;
  logic is_branch;
  logic is_io_bit;
  logic io_hit;
  logic [7:0] io_value;
  logic [1:0] cycles;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] offset_ext;
  logic [4:0] apb_io_idx;
  logic apb_io_hit;
  logic apb_write;
  logic apb_setup;

  // Handshake with the fetch path; low while a multi-cycle op drains.
  assign req_ready = (state_q == st_idle);
  assign accept = req_valid && req_ready;

  assign is_skip = (req.op == op_skip_if_reg_bit_one) ||
                   (req.op == op_skip_if_io_bit_zero) ||
                   (req.op == op_skip_if_io_bit_one);
  assign is_io_bit = (req.op == op_io_bit_force_one) ||
                     (req.op == op_io_bit_force_zero);
  assign is_branch = (req.op >= op_branch_on_flag_one) &&
                     (req.op <= op_branch_irq_disabled);

  // Addresses beyond the implemented I/O registers read as zero.
  assign io_hit = (32'(req.io_addr) < IO_REGS);
  assign io_value = io_hit ? io_q[req.io_addr] : 8'h00;

  assign offset_ext = {{(PC_W-7){req.offset[6]}}, req.offset}; // RL16

  branch_cond_eval u_cond (
    .op(req.op),
    .flag_sel(req.flag_sel),
    .bit_sel(req.bit_sel),
    .flags(flags_q),
    .reg_value(req.reg_value),
    .io_value(io_value),
    .take(take)
  );

  // Next PC and cycle cost for the accepted instruction.
  always_comb begin
    pc_next = pc_q + PC_W'(1);
    cycles = CYC_NO_SKIP;
    if (is_skip) begin
      if (take) begin
        if (req.next_two_word) begin
          pc_next = pc_q + PC_W'(3); // RL16
          cycles = CYC_SKIP_TWO_WORD; // RL16
        end else begin
          pc_next = pc_q + PC_W'(2); // RL16
          cycles = CYC_SKIP_ONE_WORD; // RL16
        end
      end
    end else if (is_branch) begin
      if (take) begin
        pc_next = pc_q + offset_ext + PC_W'(1); // RL4
        cycles = CYC_BRANCH_TAKEN;
      end else begin
        cycles = CYC_BRANCH_NOT;
      end
    end else if (is_io_bit) begin
      cycles = CYC_IO_BIT; // RL14
    end
  end

  // Sequencer: the accepting cycle is the first cycle of the op.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      stall_left_q <= 2'h0;
    end else begin
      case (state_q)
        st_idle: begin
          if (accept && cycles > 2'h1) begin
            state_q <= st_stall;
            stall_left_q <= cycles - 2'h1;
          end
        end
        st_stall: begin
          if (stall_left_q == 2'h1) begin
            state_q <= st_idle;
            stall_left_q <= 2'h0;
          end else begin
            stall_left_q <= stall_left_q - 2'h1;
          end
        end
        default: begin
          state_q <= st_idle;
          stall_left_q <= 2'h0;
        end
      endcase
    end
  end

  // APB decode.
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign apb_io_idx = paddr[6:2];
  assign apb_io_hit = (paddr[7:6] != 2'h0) && (paddr[1:0] == 2'h0) &&
                      (paddr >= OFS_IO_BASE) &&
                      (32'(paddr[7:2] - OFS_IO_BASE[7:2]) < IO_REGS);

  // The core never writes the flags; software owns them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= RST_STATUS_FLAGS;
    end else if (apb_write && paddr == OFS_STATUS_FLAGS) begin
      flags_q <= pwdata[7:0];
    end
  end

  // A core PC update wins over a software PC write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= '0;
    end else if (accept) begin
      pc_q <= pc_next;
    end else if (apb_write && paddr == OFS_PC) begin
      pc_q <= pwdata[PC_W-1:0];
    end
  end

  // Bit operations are read-modify-write at acceptance; the second cycle
  // is a bus stall, so the new value is visible from the next op on.
  // A core bit operation wins over a software write to the same register.
  for (genvar i = 0; i < IO_REGS; i++) begin : g_io
    logic core_hit;
    logic apb_hit;
    assign core_hit = accept && is_io_bit && (req.io_addr == 5'(i));
    assign apb_hit = apb_write && apb_io_hit &&
                     (apb_io_idx - OFS_IO_BASE[6:2] == 5'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        io_q[i] <= RST_IO;
      end else if (core_hit) begin
        if (req.op == op_io_bit_force_one) begin
          io_q[i][req.bit_sel] <= 1'b1; // RL14
        end else begin
          io_q[i][req.bit_sel] <= 1'b0; // RL15
        end
      end else if (apb_hit) begin
        io_q[i] <= pwdata[7:0];
      end
    end
  end

  // Statistics and the last outcome, for software to inspect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retired_q <= 32'h0;
      taken_cnt_q <= 32'h0;
      last_q <= 32'h0;
    end else if (accept) begin
      retired_q <= retired_q + 32'h1;
      if ((is_skip || is_branch) && take) begin
        taken_cnt_q <= taken_cnt_q + 32'h1;
      end
      last_q <= 32'h0;
      last_q[LAST_CYC_LSB +: 2] <= cycles;
      last_q[LAST_TAKEN_BIT] <= (is_skip || is_branch) && take;
      last_q[LAST_OP_LSB +: 5] <= req.op;
    end else if (apb_write && paddr == OFS_RETIRED) begin
      retired_q <= 32'h0;
      taken_cnt_q <= 32'h0;
    end
  end

  // Outcome report, one pulse after the last cycle of the op.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= '0;
    end else if (accept) begin
      resp_q.valid <= (cycles == 2'h1);
      resp_q.taken <= (is_skip || is_branch) && take;
      resp_q.cycles <= cycles;
    end else if (state_q == st_stall && stall_left_q == 2'h1) begin
      resp_q.valid <= 1'b1;
    end else begin
      resp_q.valid <= 1'b0;
    end
  end

  // Read data is captured in the setup phase and held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= 1'b0;
      if (paddr == OFS_STATUS_FLAGS) begin
        prdata_q <= {24'h0, flags_q};
      end else if (paddr == OFS_PC) begin
        prdata_q <= 32'(pc_q);
      end else if (paddr == OFS_RETIRED) begin
        prdata_q <= retired_q;
      end else if (paddr == OFS_TAKEN) begin
        prdata_q <= taken_cnt_q;
      end else if (paddr == OFS_LAST) begin
        prdata_q <= last_q;
      end else if (apb_io_hit) begin
        prdata_q <= {24'h0, io_q[apb_io_idx - OFS_IO_BASE[6:2]]};
      end else begin
        prdata_q <= 32'h0;
        pslverr_q <= 1'b1;
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pc = pc_q;
  assign resp = resp_q;

endmodule

`default_nettype wire

/* verif/fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fetch_model
  import exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire exec_req_t instr,
  input wire logic req_ready,
  output logic req_valid,
  output exec_req_t req
);
  // Once an instruction is taken the operand lines show the inverse of the
  // last word, so a core that samples late sees garbage, not stale data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (start) begin
      req_valid <= 1'b1;
      req <= instr;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req <= ~req;
    end
  end
endmodule

`default_nettype wire

/* verif/branch_skip_bitop_exec_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module branch_skip_bitop_exec_assertions
  import exec_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_valid,
  input wire exec_req_t req,
  input wire logic req_ready,
  input wire logic [PC_W-1:0] pc,
  input wire exec_resp_t resp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [PC_W-1:0] b_q;
  op_t o_q;
  logic [6:0] k_q;
  logic w_q;
  wire acc = req_valid && req_ready;
  wire br = o_q inside {[op_branch_on_flag_one:op_branch_irq_disabled]};
  wire sk = o_q inside {[op_skip_if_reg_bit_one:op_skip_if_io_bit_one]};
  wire bo = o_q inside {op_io_bit_force_one, op_io_bit_force_zero};
  wire [PC_W-1:0] tgt = b_q + {{(PC_W-7){k_q[6]}}, k_q} + 1'b1;

  // The pc and operands of the instruction in flight are kept here so that
  // the outcome can be judged when its response appears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_q <= '0;
      o_q <= op_nop;
      k_q <= '0;
      w_q <= 1'b0;
    end else if (acc) begin
      b_q <= pc;
      o_q <= req.op;
      k_q <= req.offset;
      w_q <= req.next_two_word;
    end
  end

  property p_pready; pready; endproperty
  property p_err; !(psel && penable) |-> !pslverr; endproperty
  property p_lat; acc |-> ##[1:3] resp.valid; endproperty
  property p_idle; resp.valid |-> req_ready; endproperty
  property p_st3;
    resp.valid && resp.cycles == CYC_SKIP_TWO_WORD
      |-> !$past(req_ready) && !$past(req_ready, 2);
  endproperty
  property p_st2;
    resp.valid && resp.cycles == CYC_SKIP_ONE_WORD |-> !$past(req_ready);
  endproperty
  property p_brt;
    resp.valid && br && resp.taken
      |-> resp.cycles == CYC_BRANCH_TAKEN && pc == tgt;
  endproperty
  property p_brn;
    resp.valid && br && !resp.taken
      |-> resp.cycles == CYC_BRANCH_NOT && pc == b_q + 1'b1;
  endproperty
  property p_skip;
    resp.valid && sk && resp.taken
      |-> resp.cycles == (w_q ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD)
      && pc == b_q + resp.cycles;
  endproperty
  property p_bit;
    resp.valid && bo |-> resp.cycles == CYC_IO_BIT && pc == b_q + 1'b1;
  endproperty

  a_pready: assert property (p_pready)
    else $error("pready low");
  a_err: assert property (p_err)
    else $error("pslverr outside access");
  a_lat: assert property (p_lat)
    else $error("no response in three cycles");
  a_idle: assert property (p_idle)
    else $error("busy at response");
  a_st3: assert property (p_st3)
    else $error("three-cycle stall wrong");
  a_st2: assert property (p_st2)
    else $error("two-cycle stall wrong");
  a_brt: assert property (p_brt)
    else $error("taken branch wrong");
  a_brn: assert property (p_brn)
    else $error("untaken branch wrong");
  a_skip: assert property (p_skip)
    else $error("skip wrong");
  a_bit: assert property (p_bit)
    else $error("bit operation cost wrong");

  c_brt: cover property (resp.valid && br && resp.taken);
  c_sk2: cover property (resp.valid && sk && w_q && resp.taken);
  c_bit: cover property (resp.valid && bo);
  c_err: cover property (psel && penable && pslverr);
endmodule

bind branch_skip_bitop_exec branch_skip_bitop_exec_assertions #(
  .PC_W(PC_W)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .pc(pc), .resp(resp)
);

`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench
  import exec_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, req_valid, req_ready, start = 0, er;
  exec_req_t req, instr = '0;
  exec_resp_t resp;
  logic [15:0] pc, epc = '0;
  int n_fail = 0, compares = 0, cyc = 0;

  always #25 pclk = ~pclk;

  branch_skip_bitop_exec i_branch_skip_bitop_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .pc(pc), .resp(resp)
  );
  fetch_model u_fetch (
    .pclk(pclk), .presetn(presetn), .start(start), .instr(instr),
    .req_ready(req_ready), .req_valid(req_valid), .req(req)
  );

  task automatic give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic take(op_t o, logic [7:0] f, logic [2:0] s,
                                logic [7:0] v);
    case (o)
      op_skip_if_reg_bit_one, op_skip_if_io_bit_one: return v[s];
      op_skip_if_io_bit_zero: return !v[s];
      op_branch_on_flag_one: return f[s];
      op_branch_on_flag_zero: return !f[s];
      op_branch_equal: return f[FLAG_Z];
      op_branch_not_equal: return !f[FLAG_Z];
      op_branch_carry_one, op_branch_lower: return f[FLAG_C];
      op_branch_carry_zero, op_branch_same_or_higher: return !f[FLAG_C];
      op_branch_minus: return f[FLAG_N];
      op_branch_plus: return !f[FLAG_N];
      op_branch_signed_ge: return !(f[FLAG_N] ^ f[FLAG_V]);
      op_branch_signed_lt: return f[FLAG_N] ^ f[FLAG_V];
      op_branch_half_carry_one: return f[FLAG_H];
      op_branch_half_carry_zero: return !f[FLAG_H];
      op_branch_transfer_bit_one: return f[FLAG_T];
      op_branch_transfer_bit_zero: return !f[FLAG_T];
      op_branch_overflow_one: return f[FLAG_V];
      op_branch_overflow_zero: return !f[FLAG_V];
      op_branch_irq_enabled: return f[FLAG_I];
      op_branch_irq_disabled: return !f[FLAG_I];
      default: return 1'b0;
    endcase
  endfunction

  task automatic exec(input op_t o, input logic [7:0] f, input logic [2:0] s,
                      input logic [7:0] v, input logic w, input logic [6:0] k);
    logic t, br, bo;
    logic [1:0] c;
    int i;
    t = take(o, f, s, v);
    br = o inside {[op_branch_on_flag_one:op_branch_irq_disabled]};
    bo = o inside {op_io_bit_force_one, op_io_bit_force_zero};
    if (br)
      c = t ? CYC_BRANCH_TAKEN : CYC_BRANCH_NOT;
    else if (bo)
      c = CYC_IO_BIT;
    else
      c = !t ? CYC_NO_SKIP : w ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
    if (br && t)
      epc = epc + {{9{k[6]}}, k} + 16'h0001;
    else if (bo)
      epc = epc + 16'h0001;
    else
      epc = epc + c;
    @(posedge pclk);
    start <= 1'b1;
    instr <= '{op: o, io_addr: 5'h03, bit_sel: s, flag_sel: s, offset: k,
               reg_value: v, next_two_word: w};
    @(posedge pclk);
    start <= 1'b0;
    for (i = 0; i < 8 && resp.valid !== 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
    chk(resp.valid === 1'b1, "no response");
    chk(bo || resp.taken === t, "taken flag");
    chk(resp.cycles === c, "cycle count");
    chk(pc === epc, "program counter");
  endtask

  task automatic sc_apb;
    apb(1'b0, OFS_STATUS_FLAGS, '0);
    chk(rd === 32'h0 && pc === 16'h0, "reset values");
    apb(1'b0, 8'h14, '0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
  endtask

  task automatic sc_branch;
    logic [7:0] tbl [5] = '{8'h00, 8'hFF, 8'h04, 8'h55, 8'hAA};
    int j;
    foreach (tbl[n]) begin
      apb(1'b1, OFS_STATUS_FLAGS, {24'h0, tbl[n]});
      for (j = op_branch_on_flag_one; j <= op_branch_irq_disabled; j++)
        exec(op_t'(j), tbl[n], 3'(j), 8'h00, 1'b0, j[0] ? 7'h7C : 7'h05);
      apb(1'b0, OFS_STATUS_FLAGS, '0);
      chk(rd[7:0] === tbl[n], "flags altered by branch");
    end
  endtask

  task automatic sc_skip;
    logic [7:0] v [3] = '{8'h00, 8'hFF, 8'h5A};
    int i, j;
    foreach (v[n]) begin
      apb(1'b1, OFS_IO_BASE + 8'h0C, {24'h0, v[n]});
      for (j = op_skip_if_reg_bit_one; j <= op_skip_if_io_bit_one; j++)
        for (i = 0; i < 4; i++)
          exec(op_t'(j), 8'h00, 3'(i * 3 + n), v[n], i[0], 7'h00);
    end
  endtask

  task automatic sc_bitop;
    apb(1'b1, OFS_STATUS_FLAGS, 32'h5A);
    apb(1'b1, OFS_IO_BASE + 8'h0C, 32'h0);
    exec(op_io_bit_force_one, 8'h5A, 3'h5, 8'h00, 1'b0, 7'h00);
    apb(1'b0, OFS_IO_BASE + 8'h0C, '0);
    chk(rd === 32'h20, "bit not set");
    apb(1'b1, OFS_IO_BASE + 8'h0C, 32'hFF);
    exec(op_io_bit_force_zero, 8'h5A, 3'h5, 8'h00, 1'b0, 7'h00);
    apb(1'b0, OFS_IO_BASE + 8'h0C, '0);
    chk(rd === 32'hDF, "bit not cleared");
    apb(1'b0, OFS_STATUS_FLAGS, '0);
    chk(rd === 32'h5A, "flags altered by bit operation");
  endtask

  // The ceiling leaves ample room over the several hundred cycles the run needs.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    sc_apb;
    sc_branch;
    sc_skip;
    sc_bitop;
    give_verdict;
  end
endmodule

`default_nettype wire
